/* File: verilog/rtimer_pkg.sv */
`default_nettype none
package rtimer_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 100_000_000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Elapsed time and duration, in tenths of a second
    localparam int unsigned TIME_W = 19;
    localparam logic [18:0] TIME_MAX = 19'h493E0;
    localparam logic [18:0] TIME_ONE = 19'h00001;
    localparam logic [18:0] ELAPSED_RST = 19'h00000;
    localparam logic [18:0] DUR_RST = 19'h493E0;

    // Register map, byte addresses
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] DUR_OFS = 5'h04;
    localparam logic [4:0] ELAP_OFS = 5'h08;
    localparam logic [4:0] STAT_OFS = 5'h0C;

    // Control fields
    localparam int unsigned RUN_POL_BIT = 0;
    localparam int unsigned CLR_POL_BIT = 1;
    localparam int unsigned OUT_POL_BIT = 2;
    localparam int unsigned SW_CLR_BIT = 3;

    // Status fields
    localparam int unsigned ST_OUT_BIT = 0;
    localparam int unsigned ST_RUN_BIT = 1;
    localparam int unsigned ST_CLR_BIT = 2;
    localparam int unsigned ST_SAT_BIT = 3;
    localparam int unsigned ST_REACH_BIT = 4;

    // Response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic out_pol;
        logic clr_pol;
        logic run_pol;
    } pol_t;

    localparam pol_t POL_RST = 3'h7;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_RUN = 3'b010,
        ST_CLEAR = 3'b100
    } tstate_t;

endpackage
`default_nettype wire

/* File: verilog/tenth_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
module tenth_prescaler #(
    parameter int unsigned DIV = rtimer_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic en_i,
    input wire logic restart_i,
    // Tick out
    output logic tick_o
);

    logic [31:0] cnt_r;
    logic tick_r;

    localparam logic [31:0] LAST = 32'(DIV - 1);

    // Counts only while enabled, so partial tenths carry across holds
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || restart_i) begin
            cnt_r <= 32'h0000_0000;
        end else if (en_i) begin
            if (cnt_r >= LAST) begin
                cnt_r <= 32'h0000_0000;
            end else begin
                cnt_r <= cnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || restart_i) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= en_i && (cnt_r >= LAST);
        end
    end

    assign tick_o = tick_r;

endmodule
`default_nettype wire

/* File: verilog/retentive_accumulating_timer.sv */
// Functional notes
// - Elapsed time advances only while run is active and clear is inactive.
// - While run is inactive the elapsed time holds its value and is not cleared.
// - Once elapsed time reaches the duration the output turns on and stays on until a clear.
// - A clear turns the output off and sets the elapsed time to zero.
// - Clear overrides run: counting stops and the elapsed time is zeroed.
// - Counting goes on past the duration while run is active and clear is not.
// - The duration setting is accepted from zero up to 30000.0 s.
// - Elapsed time reports total run time since the last clear, 0 to 30000.0 s.
// - A run polarity bit picks the run level, high or low, at which counting happens.
// - With run polarity high a rise starts activity; with it low a fall does.
// - A clear polarity bit picks whether a rise or a fall of the clear input resets.
// - An output polarity bit picks whether the asserted output is driven high or low.
// - The output asserts when elapsed time is greater than or equal to the duration.
// - Elapsed time is zero after reset and is not retained.
`timescale 1ns/1ns
`default_nettype none
module retentive_accumulating_timer #(
    parameter int unsigned TICK_CYCLES = rtimer_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Timer inputs from neighbouring logic
    input wire logic run_i,
    input wire logic clr_i,
    // Timer output
    output logic timer_out_o,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rtimer_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [rtimer_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    // Write channel holding registers
    logic aw_have_r;
    logic [rtimer_pkg::ADDR_W-1:0] aw_addr_r;
    logic w_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_fire;
    logic wr_hit;

    // Read channel
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_word;
    logic rd_hit;

    // Software-visible state
    rtimer_pkg::pol_t pol_r;
    logic [18:0] dur_r;
    logic [18:0] dur_nxt;
    logic sw_clr_r;
    logic reach_r;

    // Timer core
    logic [18:0] elapsed_r;
    logic out_act_r;
    logic out_act_nxt;
    logic timer_out_r;
    logic clr_act_d_r;
    logic run_act;
    logic clr_act;
    logic clr_edge;
    logic count_en;
    logic tick;
    logic reached;
    rtimer_pkg::tstate_t state_r;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ---------------- AXI4-Lite write path ----------------

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 5'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end

    always_comb begin
        unique case ({aw_addr_r[4:2], 2'b00})
            rtimer_pkg::CTRL_OFS,
            rtimer_pkg::DUR_OFS,
            rtimer_pkg::ELAP_OFS,
            rtimer_pkg::STAT_OFS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bvalid_r <= 1'b0;
            bresp_r <= rtimer_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? rtimer_pkg::RESP_OKAY : rtimer_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Polarity bits; elapsed reads back only, writes to it are ignored
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pol_r <= rtimer_pkg::POL_RST;
        end else if (wr_fire && w_strb_r[0]
                     && ({aw_addr_r[4:2], 2'b00} == rtimer_pkg::CTRL_OFS)) begin
            pol_r.run_pol <= w_data_r[rtimer_pkg::RUN_POL_BIT];
            pol_r.clr_pol <= w_data_r[rtimer_pkg::CLR_POL_BIT];
            pol_r.out_pol <= w_data_r[rtimer_pkg::OUT_POL_BIT];
        end
    end

    // Software clear command, one cycle, reads as zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sw_clr_r <= 1'b0;
        end else begin
            sw_clr_r <= wr_fire && w_strb_r[0] && w_data_r[rtimer_pkg::SW_CLR_BIT]
                        && ({aw_addr_r[4:2], 2'b00} == rtimer_pkg::CTRL_OFS);
        end
    end

    // Duration clamps to the top of the range
    always_comb begin
        logic [31:0] merged;
        merged = merge_strb({13'h0000, dur_r}, w_data_r, w_strb_r);
        if (merged > {13'h0000, rtimer_pkg::TIME_MAX}) begin
            dur_nxt = rtimer_pkg::TIME_MAX;
        end else begin
            dur_nxt = merged[18:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dur_r <= rtimer_pkg::DUR_RST;
        end else if (wr_fire && ({aw_addr_r[4:2], 2'b00} == rtimer_pkg::DUR_OFS)) begin
            dur_r <= dur_nxt;
        end
    end

    // ---------------- Timer core ----------------

    assign run_act = (run_i == pol_r.run_pol);
    assign clr_act = (clr_i == pol_r.clr_pol);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clr_act_d_r <= 1'b0;
        end else begin
            clr_act_d_r <= clr_act;
        end
    end

    // Clear fires on its chosen edge, or from software
    assign clr_edge = (clr_act && !clr_act_d_r) || sw_clr_r;

    // Clear, held or fresh, blocks counting
    assign count_en = run_act && !clr_act && !sw_clr_r;

    tenth_prescaler #(
        .DIV(TICK_CYCLES)
    ) u_prescaler (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(count_en),
        .restart_i(clr_edge),
        .tick_o(tick)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            elapsed_r <= rtimer_pkg::ELAPSED_RST;
        end else if (clr_edge) begin
            elapsed_r <= rtimer_pkg::ELAPSED_RST;
        end else if (tick && (elapsed_r != rtimer_pkg::TIME_MAX)) begin
            // Tick lags its tenth by one edge; run may have dropped since
            elapsed_r <= elapsed_r + rtimer_pkg::TIME_ONE;
        end
    end

    assign reached = (elapsed_r >= dur_r);

    always_comb begin
        if (clr_edge) begin
            out_act_nxt = 1'b0;
        end else if (reached && !clr_act) begin
            out_act_nxt = 1'b1;
        end else begin
            out_act_nxt = out_act_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            out_act_r <= 1'b0;
        end else begin
            out_act_r <= out_act_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            timer_out_r <= 1'b0;
        end else begin
            timer_out_r <= pol_r.out_pol ? out_act_r : !out_act_r;
        end
    end

    assign timer_out_o = timer_out_r;

    // Activity state for status
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_r <= rtimer_pkg::ST_HOLD;
        end else if (clr_act || sw_clr_r) begin
            state_r <= rtimer_pkg::ST_CLEAR;
        end else if (count_en) begin
            state_r <= rtimer_pkg::ST_RUN;
        end else begin
            state_r <= rtimer_pkg::ST_HOLD;
        end
    end

    // Sticky reached flag; a new set beats a same-cycle clear
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reach_r <= 1'b0;
        end else if (out_act_nxt && !out_act_r) begin
            reach_r <= 1'b1;
        end else if (wr_fire && w_strb_r[0] && w_data_r[rtimer_pkg::ST_REACH_BIT]
                     && ({aw_addr_r[4:2], 2'b00} == rtimer_pkg::STAT_OFS)) begin
            reach_r <= 1'b0;
        end
    end

    // ---------------- AXI4-Lite read path ----------------

    assign s_axi_arready = !rvalid_r;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[4:2], 2'b00})
            rtimer_pkg::CTRL_OFS: begin
                rd_word[rtimer_pkg::RUN_POL_BIT] = pol_r.run_pol;
                rd_word[rtimer_pkg::CLR_POL_BIT] = pol_r.clr_pol;
                rd_word[rtimer_pkg::OUT_POL_BIT] = pol_r.out_pol;
            end
            rtimer_pkg::DUR_OFS: begin
                rd_word[18:0] = dur_r;
            end
            rtimer_pkg::ELAP_OFS: begin
                rd_word[18:0] = elapsed_r;
            end
            rtimer_pkg::STAT_OFS: begin
                rd_word[rtimer_pkg::ST_OUT_BIT] = out_act_r;
                rd_word[rtimer_pkg::ST_RUN_BIT] = (state_r == rtimer_pkg::ST_RUN);
                rd_word[rtimer_pkg::ST_CLR_BIT] = (state_r == rtimer_pkg::ST_CLEAR);
                rd_word[rtimer_pkg::ST_SAT_BIT] = (elapsed_r == rtimer_pkg::TIME_MAX);
                rd_word[rtimer_pkg::ST_REACH_BIT] = reach_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rvalid_r <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= rtimer_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? rtimer_pkg::RESP_OKAY : rtimer_pkg::RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

/* File: test/run_clr_source.sv */
`timescale 1ns/1ns
`default_nettype none
module run_clr_source (
    // Clock
    input wire logic sys_clk_i,
    // Requested levels
    input wire logic run_req_i,
    input wire logic clr_req_i,
    // Levels to the timer
    output logic run_o,
    output logic clr_o
);
    initial begin
        run_o = 1'b0;
        clr_o = 1'b0;
    end
    // Relaunched on the timer clock
    always @(posedge sys_clk_i) begin
        run_o <= run_req_i;
        clr_o <= clr_req_i;
    end
endmodule
`default_nettype wire

/* File: test/rat_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module rat_checker (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic timer_out_o,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    logic [4:0] a_r;
    logic [31:0] d_r;
    logic clr_pol_r;
    logic out_pol_r;
    logic [2:0] age_r;
    // Shadow of the clear and output polarity bits, age since last write
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clr_pol_r <= 1'b1;
            out_pol_r <= 1'b1;
            age_r <= 3'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) a_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) d_r <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready && a_r == 5'h00) begin
                clr_pol_r <= d_r[1];
                out_pol_r <= d_r[2];
            end
            if (s_axi_bvalid) age_r <= 3'h0;
            else if (age_r != 3'h7) age_r <= age_r + 3'h1;
        end
    end
    wire logic clr_act = (clr_i == clr_pol_r);
    wire logic out_act = (timer_out_o == out_pol_r);
    wire logic quiet = (age_r == 3'h7);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_CLR_OUT: assert property (quiet && clr_act && !$past(clr_act) |-> ##2 !out_act)
        else $error("output not cleared by clear edge");
    AST_CLR_HOLD: assert property (quiet && clr_act && $past(clr_act) && $past(clr_act, 2)
        |-> !out_act) else $error("output active while clear held");
    AST_OUT_LATCH: assert property (quiet && out_act && !clr_act && !$past(clr_act)
        |=> out_act) else $error("output dropped without clear");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready during response");
    cover property (quiet && out_act);
    cover property (clr_act && !$past(clr_act));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind retentive_accumulating_timer rat_checker i_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clr_i(clr_i), .timer_out_o(timer_out_o),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);
`default_nettype wire

/* File: test/retentive_accumulating_timer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module retentive_accumulating_timer_tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic run_req = 1'b0;
    logic clr_req = 1'b0;
    logic run_w, clr_w, tout, awr, wr, bv, arr, rv;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h00000000, rd, got;
    logic [1:0] bresp, rresp, gresp;
    int n_fail = 0;
    int total_checks = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    run_clr_source i_src (.sys_clk_i(sys_clk_i), .run_req_i(run_req), .clr_req_i(clr_req),
        .run_o(run_w), .clr_o(clr_w));
    retentive_accumulating_timer #(.TICK_CYCLES(4)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_i(run_w), .clr_i(clr_w),
        .timer_out_o(tout), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));
    task automatic wr_chk(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        int n;
        n = 0;
        @(posedge sys_clk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (n < 40) begin
            @(negedge sys_clk_i);
            if (bv === 1'b1) break;
            aw_ok = awv && awr;
            w_ok = wv && wr;
            @(posedge sys_clk_i);
            if (aw_ok) awv <= 1'b0;
            if (w_ok) wv <= 1'b0;
            n++;
        end
        gresp = bresp;
        @(posedge sys_clk_i);
        br <= 1'b0;
        `CHK("bresp", er, gresp)
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er,
        input string nm);
        logic ar_ok;
        int n;
        n = 0;
        @(posedge sys_clk_i);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (n < 40) begin
            @(negedge sys_clk_i);
            if (rv === 1'b1) break;
            ar_ok = arv && arr;
            @(posedge sys_clk_i);
            if (ar_ok) arv <= 1'b0;
            n++;
        end
        got = rd;
        gresp = rresp;
        @(posedge sys_clk_i);
        rr <= 1'b0;
        `CHK(nm, e, got)
        `CHK("rresp", er, gresp)
    endtask
    // Levels seen by the timer for k cycles
    task automatic hold(input logic r, input logic c, input int k);
        @(posedge sys_clk_i);
        run_req <= r;
        clr_req <= c;
        repeat (k) @(posedge sys_clk_i);
    endtask
    task automatic out_chk(input logic e);
        @(negedge sys_clk_i);
        `CHK("timer_out", e, tout)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd_chk(5'h00, 32'h00000007, 2'h0, "ctrl");
        rd_chk(5'h04, 32'h000493E0, 2'h0, "duration");
        rd_chk(5'h08, 32'h00000000, 2'h0, "elapsed");
        rd_chk(5'h10, 32'h00000000, 2'h2, "unmapped");
        wr_chk(5'h14, 32'h00000001, 2'h2);
        out_chk(1'b0);
        $display("test reset done");
        wr_chk(5'h04, 32'h0007FFFF, 2'h0);
        rd_chk(5'h04, 32'h000493E0, 2'h0, "duration");
        wr_chk(5'h04, 32'h00000000, 2'h0);
        rd_chk(5'h04, 32'h00000000, 2'h0, "duration");
        out_chk(1'b1);
        wr_chk(5'h08, 32'h00000005, 2'h0);
        rd_chk(5'h08, 32'h00000000, 2'h0, "elapsed");
        wr_chk(5'h04, 32'h00000003, 2'h0);
        // Output latched at duration zero; software clear drops it
        wr_chk(5'h00, 32'h0000000F, 2'h0);
        rd_chk(5'h00, 32'h00000007, 2'h0, "ctrl");
        out_chk(1'b0);
        $display("test duration done");
        hold(1'b1, 1'b0, 8);
        hold(1'b0, 1'b0, 6);
        rd_chk(5'h08, 32'h00000002, 2'h0, "elapsed");
        out_chk(1'b0);
        hold(1'b0, 1'b0, 8);
        rd_chk(5'h08, 32'h00000002, 2'h0, "elapsed");
        hold(1'b1, 1'b0, 4);
        hold(1'b0, 1'b0, 6);
        rd_chk(5'h08, 32'h00000003, 2'h0, "elapsed");
        out_chk(1'b1);
        hold(1'b1, 1'b0, 8);
        hold(1'b0, 1'b0, 6);
        rd_chk(5'h08, 32'h00000005, 2'h0, "elapsed");
        out_chk(1'b1);
        rd_chk(5'h0C, 32'h00000011, 2'h0, "status");
        wr_chk(5'h0C, 32'h00000010, 2'h0);
        rd_chk(5'h0C, 32'h00000001, 2'h0, "status");
        $display("test count done");
        hold(1'b1, 1'b0, 6);
        hold(1'b1, 1'b1, 8);
        out_chk(1'b0);
        hold(1'b0, 1'b1, 2);
        rd_chk(5'h08, 32'h00000000, 2'h0, "elapsed");
        hold(1'b0, 1'b0, 4);
        hold(1'b1, 1'b0, 4);
        hold(1'b0, 1'b0, 6);
        rd_chk(5'h08, 32'h00000001, 2'h0, "elapsed");
        $display("test clear done");
        hold(1'b1, 1'b1, 2);
        wr_chk(5'h00, 32'h00000000, 2'h0);
        rd_chk(5'h00, 32'h00000000, 2'h0, "ctrl");
        out_chk(1'b1);
        wr_chk(5'h04, 32'h00000001, 2'h0);
        hold(1'b0, 1'b1, 4);
        hold(1'b1, 1'b1, 6);
        rd_chk(5'h08, 32'h00000001, 2'h0, "elapsed");
        out_chk(1'b0);
        hold(1'b1, 1'b0, 2);
        hold(1'b1, 1'b1, 4);
        rd_chk(5'h08, 32'h00000000, 2'h0, "elapsed");
        out_chk(1'b1);
        hold(1'b0, 1'b1, 8);
        out_chk(1'b0);
        wr_chk(5'h00, 32'h00000008, 2'h0);
        hold(1'b1, 1'b1, 6);
        rd_chk(5'h08, 32'h00000000, 2'h0, "elapsed");
        rd_chk(5'h00, 32'h00000000, 2'h0, "ctrl");
        out_chk(1'b1);
        $display("test polarity done");
        finish_test();
    end
endmodule
`default_nettype wire
